// ### hw/ppwt_timer.sv
// pulse period / width measurement timer channel with AHB-Lite slave
// assumes measure_pulse_pin and subclk are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: counter counts f1, f2, f8, f32 or subclock divided by 32
// R2: counts up; effective edge copies counter into reload register
// R3: after the copy the counter restarts at zero and keeps counting
// R4: run flag written 1 starts counting, written 0 stops it
// R5: each effective edge after the first raises the interrupt request
// R6: first effective edge after start raises no request
// R7: overflow raises a request and sets the overflow flag together
// R8: mode write at a later tick clears overflow flag while running
// R9: timer value read returns the reload register, not the counter
// R10: timer value writes change neither reload register nor counter
// R11: reload value undefined until second edge after start
// R12: edge select 00 measures falling to falling period
// R13: edge select 10 measures width between every opposite edge
// R14: run flags at bits 5 and 6 of first, bit 7 of second register
// R15: source select 00 f1/f2, 01 f8, 10 f32, 11 subclock/32
// R16: 16-bit counter, overflow on wrap, input sampled on tick
// R17: a distinct op mode code selects pulse measurement
// R18: edge select 01 and 11 are reserved and detect no edges
module ppwt_timer
   import ppwt_pkg::*;
#(
   parameter int CH = 0,          // which channel run flag drives this one
   parameter bit HALF_RATE = 1'b0 // source 00 uses f2 instead of f1
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // pins
   input  wire logic        measure_pulse_pin,
   input  wire logic        subclk,
   // interrupt
   output logic             irq
);
   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic [1:0]  pin_sync;
      logic [1:0]  sub_sync;
      logic        sub_prev;
      logic        pin_prev;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [7:0]  rd_addr;
      logic        rd_pend;
      logic [7:0]  mode;
      logic [7:0]  start1;
      logic [7:0]  start2;
      logic [15:0] cnt;
      logic [15:0] reload;
      logic        seen_first;
      logic        ovf_tick;   // a tick has passed since overflow was set
      logic [1:0]  irq_st;
      logic [1:0]  irq_mk;
      logic [31:0] rdata;
   } ppwt_state_s;

   ppwt_state_s st_ff, nxt_st;
   ppwt_tick_s  tk;
   logic        f2_tog_ff;
   logic        sub_edge;
   logic        run, tick, edge_hit, wrap, ovf_clr;

   // ***************************************************************
   // prescalers
   // ***************************************************************
   // half rate toggle for f2
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         f2_tog_ff <= 1'b0;
      end else begin
         f2_tog_ff <= ~f2_tog_ff;
      end
   end
   assign tk.f2 = f2_tog_ff;
   assign sub_edge = st_ff.sub_sync[1] & ~st_ff.sub_prev;

   ppwt_divider #(.DIV(DIV_F8)) u_div8 (
      .hclk    (hclk),
      .hresetn (hresetn),
      .en      (1'b1),
      .tick    (tk.f8)
   );
   ppwt_divider #(.DIV(DIV_F32)) u_div32 (
      .hclk    (hclk),
      .hresetn (hresetn),
      .en      (1'b1),
      .tick    (tk.f32)
   );
   ppwt_divider #(.DIV(DIV_SUB)) u_divsub (
      .hclk    (hclk),
      .hresetn (hresetn),
      .en      (sub_edge),
      .tick    (tk.subclock_div32)
   );

   // count source select [R1] [R15]
   always_comb begin
      case (st_ff.mode[POS_SRC_SEL +: 2])
         SRC_F1F2: tick = HALF_RATE ? tk.f2 : 1'b1;
         SRC_F8:   tick = tk.f8;
         SRC_F32:  tick = tk.f32;
         SRC_SUBCLOCK_DIV32: tick = tk.subclock_div32;
         default:  tick = 1'b0;
      endcase
   end

   // run flag of this channel [R4] [R14] [R17]
   always_comb begin
      case (CH)
         0:       run = st_ff.start1[POS_RUN0];
         1:       run = st_ff.start1[POS_RUN1];
         default: run = st_ff.start2[POS_RUN5];
      endcase
      run = run && (st_ff.mode[POS_OP_MODE +: 2] == OPM_MEASURE);
   end

   // effective edge on the count tick [R12] [R13] [R16] [R18]
   always_comb begin
      case (st_ff.mode[POS_EDGE_SEL +: 2])
         EDG_PERIOD: edge_hit = st_ff.pin_prev & ~st_ff.pin_sync[1];
         EDG_WIDTH:  edge_hit = st_ff.pin_prev ^ st_ff.pin_sync[1];
         default:    edge_hit = 1'b0;
      endcase
      edge_hit = edge_hit && run && tick;
   end
   assign wrap = run && tick && !edge_hit && (st_ff.cnt == 16'hffff);

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.pin_sync = {st_ff.pin_sync[0], measure_pulse_pin};
      nxt_st.sub_sync = {st_ff.sub_sync[0], subclk};
      nxt_st.sub_prev = st_ff.sub_sync[1];
      if (tick) begin
         nxt_st.pin_prev = st_ff.pin_sync[1];  // sampled on tick [R16]
      end
      // bus address phase capture
      nxt_st.wr_pend = 1'b0;
      nxt_st.rd_pend = 1'b0;
      if (hsel && hready && htrans[1]) begin
         nxt_st.wr_pend = hwrite;
         nxt_st.rd_pend = !hwrite;
         nxt_st.wr_addr = haddr;
         nxt_st.rd_addr = haddr;
      end
      // counter [R2] [R3] [R16]
      if (run && tick) begin
         if (edge_hit) begin
            nxt_st.reload = st_ff.cnt;  // [R2] [R11]
            nxt_st.cnt    = RST_CNT;    // [R3]
         end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
         end
         if (st_ff.mode[POS_OVF]) begin
            nxt_st.ovf_tick = 1'b1;
         end
      end
      if (!run) begin
         nxt_st.seen_first = 1'b0;
      end else if (edge_hit) begin
         nxt_st.seen_first = 1'b1;
      end
      // interrupt events; clear first so a set in the same cycle wins
      ovf_clr = 1'b0;
      if (st_ff.wr_pend) begin
         case (st_ff.wr_addr)
            ADDR_MODE: begin
               nxt_st.mode = {hwdata[7:6], 1'b0, st_ff.mode[4], hwdata[3:0]};
               nxt_st.mode[POS_OVF] = st_ff.mode[POS_OVF];
               ovf_clr = st_ff.ovf_tick && run;  // [R8]
            end
            ADDR_START1: nxt_st.start1 = hwdata[7:0];
            ADDR_START2: nxt_st.start2 = hwdata[7:0];
            ADDR_IRQ_ST: nxt_st.irq_st = st_ff.irq_st & ~hwdata[1:0];
            ADDR_IRQ_MK: nxt_st.irq_mk = hwdata[1:0];
            default: ;  // timer value writes ignored [R10]
         endcase
      end
      if (ovf_clr) begin
         nxt_st.mode[POS_OVF] = 1'b0;
         nxt_st.ovf_tick      = 1'b0;
      end
      if (edge_hit && st_ff.seen_first) begin
         nxt_st.irq_st[POS_IRQ_EDGE] = 1'b1;  // [R5] [R6]
      end
      if (wrap) begin
         nxt_st.irq_st[POS_IRQ_OVF] = 1'b1;   // [R7]
         nxt_st.mode[POS_OVF]       = 1'b1;
         nxt_st.ovf_tick            = 1'b0;
      end
      // read data for the next data phase
      nxt_st.rdata = 32'h0000_0000;
      if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr)
            ADDR_MODE:   nxt_st.rdata = {24'h000000, nxt_st.mode};
            ADDR_START1: nxt_st.rdata = {24'h000000, nxt_st.start1};
            ADDR_START2: nxt_st.rdata = {24'h000000, nxt_st.start2};
            ADDR_TIMER:  nxt_st.rdata = {16'h0000, nxt_st.reload};  // [R9]
            ADDR_IRQ_ST: nxt_st.rdata = {30'h00000000, nxt_st.irq_st};
            ADDR_IRQ_MK: nxt_st.rdata = {30'h00000000, nxt_st.irq_mk};
            ADDR_COUNT:  nxt_st.rdata = {16'h0000, nxt_st.cnt};
            default:     nxt_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign hrdata    = st_ff.rdata;
   assign hreadyout = 1'b1;   // zero wait states
   assign hresp     = 1'b0;   // always okay
   assign irq       = |(st_ff.irq_st & st_ff.irq_mk);

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_edge_reload: assert property ( // [R2]
      edge_hit |=> st_ff.reload == $past(st_ff.cnt))
      else $error("reload not loaded on edge");
   a_edge_zero: assert property ( // [R3]
      edge_hit |=> st_ff.cnt == 16'h0000)
      else $error("counter not cleared on edge");
   a_stop_hold: assert property ( // [R4]
      !run && !$past(run) |=> $stable(st_ff.cnt))
      else $error("counter moved while stopped");
   a_edge_irq: assert property ( // [R5]
      edge_hit && st_ff.seen_first |=> st_ff.irq_st[POS_IRQ_EDGE])
      else $error("edge request missing");
   a_first_quiet: assert property ( // [R6]
      edge_hit && !st_ff.seen_first && !st_ff.irq_st[POS_IRQ_EDGE]
      |=> !st_ff.irq_st[POS_IRQ_EDGE])
      else $error("first edge raised request");
   a_ovf_flag: assert property ( // [R7]
      wrap |=> st_ff.mode[POS_OVF] && st_ff.irq_st[POS_IRQ_OVF])
      else $error("overflow not flagged");
   a_ovf_early: assert property ( // [R8]
      wrap |=> ##1 st_ff.mode[POS_OVF])
      else $error("overflow flag cleared too early");
   a_timer_read: assert property ( // [R9]
      hsel && hready && htrans[1] && !hwrite && haddr == ADDR_TIMER
      |=> hrdata[15:0] == st_ff.reload)
      else $error("timer read not reload value");
   a_timer_write: assert property ( // [R10]
      st_ff.wr_pend && st_ff.wr_addr == ADDR_TIMER && !edge_hit
      |=> st_ff.reload == $past(st_ff.reload))
      else $error("timer write changed reload");

   // counter stepping, wrap and reload holding
   a_count_step: assert property ( // [R2]
      run && tick && !edge_hit
      |=> st_ff.cnt == 16'($past(st_ff.cnt) + 16'h0001))
      else $error("counter did not step on tick");
   a_wrap_zero: assert property ( // [R16]
      wrap |=> st_ff.cnt == 16'h0000)
      else $error("counter not zero after wrap");
   a_reload_hold: assert property ( // [R2]
      !edge_hit |=> $stable(st_ff.reload))
      else $error("reload changed without an edge");
   a_stop_reload: assert property ( // [R4]
      !run |=> $stable(st_ff.reload))
      else $error("reload changed while stopped");

   // edge decode per edge select code
   a_period_fall: assert property ( // [R12]
      run && tick && st_ff.mode[POS_EDGE_SEL +: 2] == EDG_PERIOD
      && st_ff.pin_prev && !st_ff.pin_sync[1] |-> edge_hit)
      else $error("falling edge missed");
   a_period_rise: assert property ( // [R12]
      st_ff.mode[POS_EDGE_SEL +: 2] == EDG_PERIOD && !st_ff.pin_prev
      |-> !edge_hit)
      else $error("rising edge taken in period mode");
   a_width_edges: assert property ( // [R13]
      run && tick && st_ff.mode[POS_EDGE_SEL +: 2] == EDG_WIDTH
      && (st_ff.pin_prev != st_ff.pin_sync[1]) |-> edge_hit)
      else $error("width edge missed");
   a_reserved_edge: assert property ( // [R18]
      st_ff.mode[POS_EDGE_SEL] |-> !edge_hit)
      else $error("edge seen with a reserved edge code");
   a_first_reset: assert property ( // [R6]
      !run |=> !st_ff.seen_first)
      else $error("first edge marker kept while stopped");

   // sticky status and overflow flag
   a_edge_sticky: assert property ( // [R5]
      st_ff.irq_st[POS_IRQ_EDGE]
      && !(st_ff.wr_pend && st_ff.wr_addr == ADDR_IRQ_ST)
      |=> st_ff.irq_st[POS_IRQ_EDGE])
      else $error("edge status lost without a clear");
   a_ovf_cause: assert property ( // [R7]
      !wrap && !st_ff.irq_st[POS_IRQ_OVF] |=> !st_ff.irq_st[POS_IRQ_OVF])
      else $error("overflow status set without a wrap");
   a_ovf_stopped: assert property ( // [R8]
      !run && st_ff.mode[POS_OVF] |=> st_ff.mode[POS_OVF])
      else $error("overflow flag cleared while stopped");
   a_clear_wait: assert property ( // [R8]
      st_ff.mode[POS_OVF] && !st_ff.ovf_tick |=> st_ff.mode[POS_OVF])
      else $error("overflow flag cleared before a tick");

   // data phase read data
   a_rdata_idle: assert property ( // [R9]
      !st_ff.rd_pend |-> hrdata == 32'h0000_0000)
      else $error("read data outside a read data phase");
   a_unmapped_read: assert property ( // [R9]
      st_ff.rd_pend && st_ff.rd_addr > ADDR_COUNT
      |-> hrdata == 32'h0000_0000)
      else $error("unmapped read returned data");

   // main scenarios reached
   c_period: cover property (edge_hit && st_ff.mode[3:2] == EDG_PERIOD);
   c_width: cover property (edge_hit && st_ff.mode[3:2] == EDG_WIDTH);
   c_wrap: cover property (wrap);
   c_irq: cover property (irq);
   c_reserved: cover property (run && tick && st_ff.mode[POS_EDGE_SEL]);
endmodule
`default_nettype wire

// ### hw/ppwt_pkg.sv
// package for the pulse period / width timer channel
// assumes a single 200 MHz system clock and an AHB-Lite register slave
package ppwt_pkg;

   // ***************************************************************
   // register map (byte addresses)
   // ***************************************************************
   localparam logic [7:0] ADDR_MODE   = 8'h00;  // channel_mode_reg
   localparam logic [7:0] ADDR_START1 = 8'h04;  // start_reg_first
   localparam logic [7:0] ADDR_START2 = 8'h08;  // start_reg_second
   localparam logic [7:0] ADDR_TIMER  = 8'h0c;  // timer_value_reg
   localparam logic [7:0] ADDR_IRQ_ST = 8'h10;  // sticky status
   localparam logic [7:0] ADDR_IRQ_MK = 8'h14;  // interrupt mask
   localparam logic [7:0] ADDR_COUNT  = 8'h18;  // live counter (read only)

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int POS_OP_MODE  = 0;  // op_mode_hi:op_mode_lo
   localparam int POS_EDGE_SEL = 2;  // edge_select_hi:edge_select_lo
   localparam int POS_OVF      = 5;  // overflow_flag
   localparam int POS_SRC_SEL  = 6;  // source_select_hi:source_select_lo
   localparam int POS_RUN0     = 5;  // channel 0 run flag, first start reg
   localparam int POS_RUN1     = 6;  // channel 1 run flag, first start reg
   localparam int POS_RUN5     = 7;  // channel 5 run flag, second start reg
   localparam int POS_IRQ_EDGE = 0;
   localparam int POS_IRQ_OVF  = 1;

   // ***************************************************************
   // encodings and reset values
   // ***************************************************************
   localparam logic [1:0] OPM_MEASURE = 2'h2;
   localparam logic [1:0] EDG_PERIOD  = 2'h0;
   localparam logic [1:0] EDG_WIDTH   = 2'h2;
   localparam logic [1:0] SRC_F1F2    = 2'h0;
   localparam logic [1:0] SRC_F8      = 2'h1;
   localparam logic [1:0] SRC_F32     = 2'h2;
   localparam logic [1:0] SRC_SUBCLOCK_DIV32    = 2'h3;
   localparam logic [7:0] RST_MODE    = 8'h00;
   localparam logic [15:0] RST_CNT    = 16'h0000;
   localparam int DIV_F8  = 8;
   localparam int DIV_F32 = 32;
   localparam int DIV_SUB = 32;

   // grouped prescaler ticks
   typedef struct packed {
      logic f2;
      logic f8;
      logic f32;
      logic subclock_div32;
   } ppwt_tick_s;

endpackage

// ### hw/ppwt_divider.sv
// prescale divider: one-cycle tick every DIV enables of en
// assumes en is a same-clock strobe
`timescale 1ns/1ps
`default_nettype none
module ppwt_divider
   import ppwt_pkg::*;
#(
   parameter int DIV = 8
) (
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // count enable in, tick out
   input  wire logic en,
   output logic      tick
);
   logic [5:0] cnt_ff;

   // modulo counter, advanced only on cycles with en high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff <= 6'h00;
      end else if (en) begin
         cnt_ff <= (cnt_ff == 6'(DIV - 1)) ? 6'h00 : cnt_ff + 6'h01;
      end
   end

   assign tick = en && (cnt_ff == 6'(DIV - 1));
endmodule
`default_nettype wire

// ### verification/ppwt_pulse_src.sv
// external pulse source driving the measurement pin
// assumes lengths are in hclk cycles and are set while en is low
`timescale 1ns/1ps
`default_nettype none
module ppwt_pulse_src (
   // clock
   input  wire logic        hclk,
   // pattern control from the bench
   input  wire logic        en,
   input  wire logic [15:0] hi_len,
   input  wire logic [15:0] lo_len,
   // measurement pin
   output logic             pin
);
   logic [15:0] cnt;

   initial pin = 1'b1;

   // idle high; while enabled, high for hi_len then low for lo_len
   always @(posedge hclk) begin
      if (!en) begin
         pin <= 1'b1;
         cnt <= 16'h0001;
      end else if (cnt >= (pin ? hi_len : lo_len)) begin
         pin <= ~pin;
         cnt <= 16'h0001;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ### verification/test_pulse_period_width_timer.sv
// self-checking bench for the pulse period / width timer channel
// assumes ppwt_pkg, ppwt_timer and ppwt_pulse_src are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_pulse_period_width_timer;
   import ppwt_pkg::*;
   typedef struct {
      logic [1:0] src;
      logic [1:0] edg;
      int         half;
      int         step;
      int         ticks;
   } ppwt_row_s;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        subclk = 1'b0;
   logic        en = 1'b0;
   logic [15:0] hi_len = 16'h000a;
   logic [15:0] lo_len = 16'h000a;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        irq;
   logic        pin;
   logic [31:0] rd;
   logic [31:0] r1;
   logic [31:0] c;
   logic [31:0] m;
   int          n_errors = 0;
   int          n_checks = 0;
   // source, edge select, half period, added length, expected tick delta
   ppwt_row_s   rows[7] = '{
      '{SRC_F1F2, EDG_PERIOD, 20, 10, 20},
      '{SRC_F8, EDG_PERIOD, 40, 16, 4},
      '{SRC_F32, EDG_PERIOD, 64, 32, 2},
      '{SRC_SUBCLOCK_DIV32, EDG_PERIOD, 256, 256, 4},
      '{SRC_F1F2, EDG_WIDTH, 20, 10, 10},
      '{SRC_F8, EDG_WIDTH, 40, 16, 2},
      '{SRC_F1F2, 2'h1, 20, 10, 0}
   };

   // system clock and free-running subclock, four system cycles apart
   always #2.5 hclk = ~hclk;
   always #10 subclk = ~subclk;

   ppwt_timer #(.CH(0), .HALF_RATE(1'b0)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .measure_pulse_pin(pin),
      .subclk(subclk), .irq(irq));
   ppwt_pulse_src i_src (.hclk(hclk), .en(en), .hi_len(hi_len),
      .lo_len(lo_len), .pin(pin));

   // ***************************************************************
   // bus and check tasks
   // ***************************************************************
   task automatic finish_test;
      if (n_errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask

   // wait for hready, bounded; a stuck bus ends the run
   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (hreadyout !== 1'b1) begin
         n_errors++;
         finish_test();
      end
   endtask

   // one single word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rdat);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rdat = hrdata;
   endtask

   // restart the channel and run four equal-half periods
   task automatic measure(input logic [31:0] md, input int half,
                          output logic [31:0] res);
      bus(1'b1, ADDR_START1, 32'h0, rd);
      bus(1'b1, ADDR_MODE, md, rd);
      hi_len <= 16'(half);
      lo_len <= 16'(half);
      bus(1'b1, ADDR_START1, 32'h1 << POS_RUN0, rd);
      en <= 1'b1;
      repeat (8 * half + 16) @(posedge hclk);
      bus(1'b0, ADDR_TIMER, 32'h0, res);
      en <= 1'b0;
   endtask

   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values, unmapped word included
      for (int a = 0; a < 32; a += 4) begin
         bus(1'b0, 8'(a), 32'h0, rd);
         chk("reset_read", 32'h0, rd);
      end
      chk("hresp", 32'h0, {31'h0, hresp});
      // measurement table: change of result against change of length
      foreach (rows[i]) begin
         m = 32'(rows[i].src) << POS_SRC_SEL;
         m = m | (32'(rows[i].edg) << POS_EDGE_SEL) | 32'(OPM_MEASURE);
         measure(m, rows[i].half, r1);
         measure(m, rows[i].half + rows[i].step, rd);
         chk("delta", 32'(rows[i].ticks), rd - r1);
      end
      // first edge after start is silent, second raises the request
      m = 32'(OPM_MEASURE);
      bus(1'b1, ADDR_START1, 32'h0, rd);
      bus(1'b1, ADDR_MODE, m, rd);
      bus(1'b1, ADDR_IRQ_ST, 32'h3, rd);
      bus(1'b1, ADDR_IRQ_MK, 32'h3, rd);
      hi_len <= 16'h000a;
      lo_len <= 16'h03e8;
      bus(1'b1, ADDR_START1, 32'h20, rd);
      en <= 1'b1;
      repeat (40) @(posedge hclk);
      bus(1'b0, ADDR_IRQ_ST, 32'h0, rd);
      chk("edge_status", 32'h0, rd);
      chk("irq_first", 32'h0, {31'h0, irq});
      en <= 1'b0;
      repeat (5) @(posedge hclk);
      en <= 1'b1;
      repeat (40) @(posedge hclk);
      bus(1'b0, ADDR_IRQ_ST, 32'h0, rd);
      chk("edge_status", 32'h1, rd);
      chk("irq_edge", 32'h1, {31'h0, irq});
      bus(1'b1, ADDR_IRQ_MK, 32'h0, rd);
      @(negedge hclk);
      chk("irq_masked", 32'h0, {31'h0, irq});
      bus(1'b1, ADDR_IRQ_ST, 32'h1, rd);
      bus(1'b0, ADDR_IRQ_ST, 32'h0, rd);
      chk("status_w1c", 32'h0, rd);
      // timer writes ignored; other channels' run flags do not start it
      bus(1'b1, ADDR_START1, 32'h0, rd);
      bus(1'b0, ADDR_TIMER, 32'h0, r1);
      bus(1'b0, ADDR_COUNT, 32'h0, c);
      bus(1'b1, ADDR_TIMER, 32'h0000ffff, rd);
      bus(1'b1, ADDR_START1, 32'h40, rd);
      bus(1'b1, ADDR_START2, 32'h80, rd);
      bus(1'b0, ADDR_TIMER, 32'h0, rd);
      chk("timer_write", r1, rd);
      bus(1'b0, ADDR_COUNT, 32'h0, rd);
      chk("count_held", c, rd);
      // overflow with a quiet pin, then cleared by a mode write
      en <= 1'b0;
      bus(1'b1, ADDR_IRQ_ST, 32'h3, rd);
      bus(1'b1, ADDR_START1, 32'h20, rd);
      rd = 32'h0;
      for (int k = 0; k < 24000 && rd[1] !== 1'b1; k++)
         bus(1'b0, ADDR_IRQ_ST, 32'h0, rd);
      chk("ovf_status", 32'h2, rd);
      if (rd[1] !== 1'b1)
         finish_test();
      bus(1'b0, ADDR_MODE, 32'h0, rd);
      chk("ovf_flag", m | 32'h20, rd);
      bus(1'b1, ADDR_MODE, m, rd);
      bus(1'b0, ADDR_MODE, 32'h0, rd);
      chk("ovf_cleared", m, rd);
      finish_test();
   end
endmodule
`default_nettype wire
